// ### rtl/nco_hop_phase_offset.sv
// Hop phase offset and frequency tables with two oscillator channels.
// Assumes an APB master on pclk; the sample clock is pclk itself.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "nco_hop_cfg.svh"

// Overview of operation
// - Selected phase word sits in top 16 of 32 bits, zeros below, then added.
// - Offset equals word times 2^-16 of a full cycle.
// - Offset is added after the accumulator; table writes need no oscillator reset.
// - Phase word is modular; signed and unsigned readings give the same phase.
// - Channel B phase table starts at index 4A0h, entry n at base plus 2n.
// - All sixteen phase entries of each channel reset to zero.
// - Channel A phase table starts at index 480h, step two, reset zero.
// - Each select also picks a 32-bit frequency word; step is word times 2^-32.
module nco_hop_phase_offset (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Oscillator phase outputs
   output logic [31:0] phase_out_a,
   output logic [31:0] phase_out_b
);

   // =====================================================================
   // Address decode
   // Unmapped words, odd phase indices and misaligned freq indices miss
   function automatic nco_hop_pkg::reg_sel_t decode(input logic [31:0] addr);
      logic [11:0] idx;
      logic [11:0] off;
      nco_hop_pkg::reg_sel_t sel;
      idx = addr[13:2];
      off = 12'h000;
      sel.target = nco_hop_pkg::TGT_NONE;
      sel.tbl = nco_hop_pkg::TBL_FREQ_A;
      sel.entry = 4'h0;
      if (addr[31:14] == 18'h00000 && addr[1:0] == 2'h0) begin
         if (idx == `HOP_IDX_CTRL) begin
            sel.target = nco_hop_pkg::TGT_CTRL;
         end else if (idx == `HOP_IDX_SELECT) begin
            sel.target = nco_hop_pkg::TGT_SELECT;
         end else if (idx == `HOP_IDX_PHASE_OUT_A) begin
            sel.target = nco_hop_pkg::TGT_OUT_A;
         end else if (idx == `HOP_IDX_PHASE_OUT_B) begin
            sel.target = nco_hop_pkg::TGT_OUT_B;
         end else if (idx >= `HOP_IDX_FREQ_A && idx < `HOP_IDX_FREQ_A + `HOP_FREQ_SPAN) begin
            off = idx - `HOP_IDX_FREQ_A;
            sel.tbl = nco_hop_pkg::TBL_FREQ_A;
         end else if (idx >= `HOP_IDX_FREQ_B && idx < `HOP_IDX_FREQ_B + `HOP_FREQ_SPAN) begin
            off = idx - `HOP_IDX_FREQ_B;
            sel.tbl = nco_hop_pkg::TBL_FREQ_B;
         end else if (idx >= `HOP_IDX_PHASE_A && idx < `HOP_IDX_PHASE_A + `HOP_PHASE_SPAN) begin
            off = idx - `HOP_IDX_PHASE_A;
            sel.tbl = nco_hop_pkg::TBL_PHASE_A;
         end else if (idx >= `HOP_IDX_PHASE_B && idx < `HOP_IDX_PHASE_B + `HOP_PHASE_SPAN) begin
            off = idx - `HOP_IDX_PHASE_B;
            sel.tbl = nco_hop_pkg::TBL_PHASE_B;
         end
         // Frequency entries step by four indices, phase entries by two
         if (sel.target == nco_hop_pkg::TGT_NONE && off != 12'h000 || idx >= `HOP_IDX_FREQ_A) begin
            if (sel.tbl == nco_hop_pkg::TBL_FREQ_A || sel.tbl == nco_hop_pkg::TBL_FREQ_B) begin
               if (off[1:0] == 2'h0 && idx >= `HOP_IDX_FREQ_A && idx < `HOP_IDX_PHASE_A) begin
                  sel.target = nco_hop_pkg::TGT_TABLE;
                  sel.entry = off[5:2];
               end
            end else if (off[0] == 1'b0 && idx >= `HOP_IDX_PHASE_A
                         && idx < `HOP_IDX_PHASE_B + `HOP_PHASE_SPAN) begin
               sel.target = nco_hop_pkg::TGT_TABLE;
               sel.entry = off[4:1];
            end
         end
      end
      return sel;
   endfunction : decode

   // =====================================================================
   // Bus state
   nco_hop_pkg::reg_sel_t bus_sel;
   logic setup_phase;
   logic wr_commit;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   nco_hop_pkg::osc_ctrl_t ctrl_q, ctrl_d;
   logic [3:0] sel_a_q, sel_a_d;
   logic [3:0] sel_b_q, sel_b_d;

   // Table ports
   logic [15:0] ph_a_rd, ph_b_rd, ph_a_hop, ph_b_hop;
   logic [31:0] fr_a_rd, fr_b_rd, fr_a_hop, fr_b_hop;
   logic wr_fa, wr_fb, wr_pa, wr_pb;

   // Oscillator state
   logic [15:0] phase_word_a_q, phase_word_a_d;
   logic [15:0] phase_word_b_q, phase_word_b_d;
   logic [31:0] freq_word_a_q, freq_word_a_d;
   logic [31:0] freq_word_b_q, freq_word_b_d;
   logic [31:0] acc_a_q, acc_a_d;
   logic [31:0] acc_b_q, acc_b_d;
   logic [31:0] out_a_q, out_a_d;
   logic [31:0] out_b_q, out_b_d;

   assign bus_sel = decode(paddr);
   assign setup_phase = psel && !penable;
   // A write lands only at the edge where the access phase sees pready
   assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;
   assign wr_fa = wr_commit && bus_sel.target == nco_hop_pkg::TGT_TABLE && bus_sel.tbl == nco_hop_pkg::TBL_FREQ_A;
   assign wr_fb = wr_commit && bus_sel.target == nco_hop_pkg::TGT_TABLE && bus_sel.tbl == nco_hop_pkg::TBL_FREQ_B;
   assign wr_pa = wr_commit && bus_sel.target == nco_hop_pkg::TGT_TABLE && bus_sel.tbl == nco_hop_pkg::TBL_PHASE_A;
   assign wr_pb = wr_commit && bus_sel.target == nco_hop_pkg::TGT_TABLE && bus_sel.tbl == nco_hop_pkg::TBL_PHASE_B;

   // =====================================================================
   // Tables
   hop_table #(.WIDTH(32), .RESET_VALUE(`HOP_FREQ_RESET)) u_freq_a (
      .pclk(pclk), .presetn(presetn), .wr_en(wr_fa), .wr_entry(bus_sel.entry), .wr_data(pwdata),
      .rd_entry(bus_sel.entry), .rd_data(fr_a_rd), .hop_entry(sel_a_q), .hop_data(fr_a_hop)
   );
   hop_table #(.WIDTH(32), .RESET_VALUE(`HOP_FREQ_RESET)) u_freq_b (
      .pclk(pclk), .presetn(presetn), .wr_en(wr_fb), .wr_entry(bus_sel.entry), .wr_data(pwdata),
      .rd_entry(bus_sel.entry), .rd_data(fr_b_rd), .hop_entry(sel_b_q), .hop_data(fr_b_hop)
   );
   hop_table #(.WIDTH(16), .RESET_VALUE(`HOP_PHASE_RESET)) u_phase_a (
      .pclk(pclk), .presetn(presetn), .wr_en(wr_pa), .wr_entry(bus_sel.entry), .wr_data(pwdata[15:0]),
      .rd_entry(bus_sel.entry), .rd_data(ph_a_rd), .hop_entry(sel_a_q), .hop_data(ph_a_hop)
   );
   hop_table #(.WIDTH(16), .RESET_VALUE(`HOP_PHASE_RESET)) u_phase_b (
      .pclk(pclk), .presetn(presetn), .wr_en(wr_pb), .wr_entry(bus_sel.entry), .wr_data(pwdata[15:0]),
      .rd_entry(bus_sel.entry), .rd_data(ph_b_rd), .hop_entry(sel_b_q), .hop_data(ph_b_hop)
   );

   // =====================================================================
   // APB answer and control registers
   // Read data and pready are prepared in the setup cycle so every
   // access takes exactly one access cycle, at the cost of one flop stage
   always_comb begin
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      ctrl_d = ctrl_q;
      sel_a_d = sel_a_q;
      sel_b_d = sel_b_q;
      if (setup_phase) begin
         pready_d = 1'b1;
         pslverr_d = (bus_sel.target == nco_hop_pkg::TGT_NONE);
         prdata_d = 32'h0000_0000;
         case (bus_sel.target)
            nco_hop_pkg::TGT_CTRL: prdata_d[`HOP_CTRL_CHGBLK_BIT:`HOP_CTRL_ENABLE_BIT] = ctrl_q;
            nco_hop_pkg::TGT_SELECT: begin
               prdata_d[`HOP_SEL_A_LSB +: 4] = sel_a_q;
               prdata_d[`HOP_SEL_B_LSB +: 4] = sel_b_q;
            end
            nco_hop_pkg::TGT_OUT_A: prdata_d = out_a_q;
            nco_hop_pkg::TGT_OUT_B: prdata_d = out_b_q;
            nco_hop_pkg::TGT_TABLE: begin
               case (bus_sel.tbl)
                  nco_hop_pkg::TBL_FREQ_A: prdata_d = fr_a_rd;
                  nco_hop_pkg::TBL_FREQ_B: prdata_d = fr_b_rd;
                  nco_hop_pkg::TBL_PHASE_A: prdata_d[15:0] = ph_a_rd;
                  default: prdata_d[15:0] = ph_b_rd;
               endcase
            end
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      if (wr_commit && bus_sel.target == nco_hop_pkg::TGT_CTRL) begin
         ctrl_d = pwdata[`HOP_CTRL_CHGBLK_BIT:`HOP_CTRL_ENABLE_BIT];
      end
      if (wr_commit && bus_sel.target == nco_hop_pkg::TGT_SELECT) begin
         sel_a_d = pwdata[`HOP_SEL_A_LSB +: 4];
         sel_b_d = pwdata[`HOP_SEL_B_LSB +: 4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         ctrl_q <= `HOP_CTRL_RESET;
         sel_a_q <= `HOP_SEL_RESET;
         sel_b_q <= `HOP_SEL_RESET;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         ctrl_q <= ctrl_d;
         sel_a_q <= sel_a_d;
         sel_b_q <= sel_b_d;
      end
   end

   // =====================================================================
   // Oscillators
   // The applied words follow the current select each cycle, so a hop or a
   // table write shows one cycle later; change-block freezes them so that
   // software can rewrite tables safely while running
   always_comb begin
      phase_word_a_d = phase_word_a_q;
      phase_word_b_d = phase_word_b_q;
      freq_word_a_d = freq_word_a_q;
      freq_word_b_d = freq_word_b_q;
      if (!ctrl_q.change_block) begin
         phase_word_a_d = ph_a_hop;
         phase_word_b_d = ph_b_hop;
         freq_word_a_d = fr_a_hop;
         freq_word_b_d = fr_b_hop;
      end
      // Accumulator wraps at 2^32, one step of freq per sample
      acc_a_d = ctrl_q.enable ? acc_a_q + freq_word_a_q : 32'h0000_0000;
      acc_b_d = ctrl_q.enable ? acc_b_q + freq_word_b_q : 32'h0000_0000;
      // Late add: the offset never touches the accumulator
      // Modular 32-bit add makes signed and unsigned words equal
      // Word at the top, so one LSB is 2^-16 of a cycle
      out_a_d = acc_a_q + {phase_word_a_q, `HOP_PHASE_LOW_ZERO};
      out_b_d = acc_b_q + {phase_word_b_q, `HOP_PHASE_LOW_ZERO};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_word_a_q <= `HOP_PHASE_RESET;
         phase_word_b_q <= `HOP_PHASE_RESET;
         freq_word_a_q <= `HOP_FREQ_RESET;
         freq_word_b_q <= `HOP_FREQ_RESET;
         acc_a_q <= 32'h0000_0000;
         acc_b_q <= 32'h0000_0000;
         out_a_q <= 32'h0000_0000;
         out_b_q <= 32'h0000_0000;
      end else begin
         phase_word_a_q <= phase_word_a_d;
         phase_word_b_q <= phase_word_b_d;
         freq_word_a_q <= freq_word_a_d;
         freq_word_b_q <= freq_word_b_d;
         acc_a_q <= acc_a_d;
         acc_b_q <= acc_b_d;
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
      end
   end

   // =====================================================================
   // Outputs, all from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign phase_out_a = out_a_q;
   assign phase_out_b = out_b_q;

endmodule : nco_hop_phase_offset

// ### rtl/nco_hop_cfg.svh
// Register map and field constants for the hop phase offset block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef NCO_HOP_CFG_SVH
`define NCO_HOP_CFG_SVH

// =====================================================================
// Word indices (byte address is four times the index)
`define HOP_IDX_CTRL       12'h000
`define HOP_IDX_SELECT     12'h001
`define HOP_IDX_PHASE_OUT_A 12'h002
`define HOP_IDX_PHASE_OUT_B 12'h003
`define HOP_IDX_FREQ_A     12'h400
`define HOP_IDX_FREQ_B     12'h440
`define HOP_IDX_PHASE_A    12'h480
`define HOP_IDX_PHASE_B    12'h4a0
// Index span of one table (16 entries)
`define HOP_FREQ_SPAN      12'h040
`define HOP_PHASE_SPAN     12'h020

// =====================================================================
// Field positions
`define HOP_CTRL_ENABLE_BIT  0
`define HOP_CTRL_CHGBLK_BIT  1
`define HOP_SEL_A_LSB        0
`define HOP_SEL_B_LSB        8

// =====================================================================
// Reset values
`define HOP_PHASE_RESET    16'h0000
`define HOP_FREQ_RESET     32'h0000_0000
`define HOP_CTRL_RESET     2'h0
`define HOP_SEL_RESET      4'h0
`define HOP_PHASE_LOW_ZERO 16'h0000

`endif

// ### rtl/nco_hop_pkg.sv
// Types shared by the hop phase offset block.
// Assumes nco_hop_cfg.svh provides the numeric constants.
package nco_hop_pkg;

   // =====================================================================
   // Register targets
   typedef enum logic [2:0] {
      TGT_NONE   = 3'h0,
      TGT_CTRL   = 3'h1,
      TGT_SELECT = 3'h2,
      TGT_OUT_A  = 3'h3,
      TGT_OUT_B  = 3'h4,
      TGT_TABLE  = 3'h5
   } reg_target_t;

   // Which of the four hop tables
   typedef enum logic [1:0] {
      TBL_FREQ_A  = 2'h0,
      TBL_FREQ_B  = 2'h1,
      TBL_PHASE_A = 2'h2,
      TBL_PHASE_B = 2'h3
   } table_id_t;

   // Decoded register address
   typedef struct packed {
      reg_target_t target;
      table_id_t tbl;
      logic [3:0] entry;
   } reg_sel_t;

   // Oscillator control bits
   typedef struct packed {
      logic change_block;
      logic enable;
   } osc_ctrl_t;

endpackage : nco_hop_pkg

// ### rtl/hop_table.sv
// Sixteen-entry hop word table with one write port and two read ports.
// Assumes writes come from the bus slave on the same clock.
`timescale 1ns/1ps
module hop_table #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write port
   input wire logic wr_en,
   input wire logic [3:0] wr_entry,
   input wire logic [WIDTH-1:0] wr_data,
   // Bus read port
   input wire logic [3:0] rd_entry,
   output logic [WIDTH-1:0] rd_data,
   // Oscillator read port, indexed by the hop select
   input wire logic [3:0] hop_entry,
   output logic [WIDTH-1:0] hop_data
);

   // =====================================================================
   // Storage
   logic [WIDTH-1:0] mem_q [16];
   logic [WIDTH-1:0] mem_d [16];

   // Next contents: one entry replaced on a write
   always_comb begin
      mem_d = mem_q;
      if (wr_en) begin
         mem_d[wr_entry] = wr_data;
      end
   end

   // All entries clear on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 16; i++) begin
            mem_q[i] <= RESET_VALUE;
         end
      end else begin
         mem_q <= mem_d;
      end
   end

   // Read ports are plain muxes; the caller registers them
   assign rd_data = mem_q[rd_entry];
   assign hop_data = mem_q[hop_entry];

endmodule : hop_table

// ### tb/nco_hop_phase_offset_assertions.sv
// Port-level checker for the hop phase offset block.
// Assumes it is bound to nco_hop_phase_offset and sees only its ports.
`timescale 1ns/1ps
module nco_hop_phase_offset_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Phase outputs
   input wire logic [31:0] phase_out_a,
   input wire logic [31:0] phase_out_b
);
   // =====================================================================
   // Shadow of the enable bit, and quiet cycles since the last write
   logic en_q, en_d, wr_c;
   logic [2:0] quiet_q, quiet_d;
   always_comb begin
      wr_c = psel && penable && pready && pwrite;
      en_d = (wr_c && paddr == 32'h0) ? pwdata[0] : en_q;
      quiet_d = wr_c ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
   end
   // Saturating count: seven idle cycles outlast every documented latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         quiet_q <= 3'h0;
      end else begin
         en_q <= en_d;
         quiet_q <= quiet_d;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================================
   // Properties
   property p_rdy_setup; psel && !penable |=> pready; endproperty
   a_rdy_setup: assert property (p_rdy_setup) else $error("no answer after setup");
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
   property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error without ready or zero data");
   property p_odd_ref; psel && penable && pready && paddr[31:8] == 24'h12 && paddr[2] |-> pslverr; endproperty
   a_odd_ref: assert property (p_odd_ref) else $error("odd phase index accepted");
   property p_upper_zero; pready && !pwrite && !pslverr && paddr[31:8] == 24'h12 |-> prdata[31:16] == 16'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("phase word read with upper bits");
   property p_rst_zero; !$past(presetn) |-> phase_out_a == 32'h0 && phase_out_b == 32'h0; endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("phase not zero after reset");
   property p_low_zero; !en_q && quiet_q == 3'h7 |-> phase_out_a[15:0] == 16'h0 && phase_out_b[15:0] == 16'h0;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("phase word not left justified");
   property p_hold; !en_q && quiet_q == 3'h7 |-> $stable(phase_out_a) && $stable(phase_out_b); endproperty
   a_hold: assert property (p_hold) else $error("phase moved without a write");
endmodule : nco_hop_phase_offset_assertions

bind nco_hop_phase_offset nco_hop_phase_offset_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .phase_out_a(phase_out_a), .phase_out_b(phase_out_b));

// ### tb/test_nco_hop_phase_offset.sv
// Self-checking bench for the hop phase offset block.
// Assumes a one-access-cycle APB slave; table models live in arrays here.
`timescale 1ns/1ps
module test_nco_hop_phase_offset;
   // =====================================================================
   // Drive, reference tables and counters
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, phase_out_a, phase_out_b, rd, f, fb, p0, q0;
   logic pready, pslverr, er;
   logic [15:0] pa [16];
   logic [15:0] pb [16];
   logic [15:0] w;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   int c0;
   integer seed = 32'ha48b;

   always #5 pclk = ~pclk;

   nco_hop_phase_offset dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phase_out_a(phase_out_a), .phase_out_b(phase_out_b));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One transfer; request held until pready is seen at an edge.
   // No local limit: only the bench's cycle guard may end a wait.
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string what, input logic [31:0] addr, input logic [31:0] exp, input logic e);
      apb(1'b0, addr, 32'h0);
      chk(what, exp, rd);
      chk("pslverr", {31'h0, e}, {31'h0, er});
   endtask : rdchk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   // Cycle count and hang guard, far above the few hundred cycles used
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end

   // =====================================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int n = 0; n < 16; n++) begin
         rdchk("phase_a reset", 32'h1200 + 32'(8 * n), 32'h0, 1'b0);
         rdchk("phase_b reset", 32'h1280 + 32'(8 * n), 32'h0, 1'b0);
         f = $random(seed);
         pa[n] = f[15:0];
         apb(1'b1, 32'h1200 + 32'(8 * n), f);
         f = $random(seed);
         pb[n] = f[15:0];
         apb(1'b1, 32'h1280 + 32'(8 * n), f);
      end
      // Odd index and unmapped place are refused and leave tables alone
      apb(1'b1, 32'h1284, 32'hffff_ffff);
      chk("odd write err", 32'h1, {31'h0, er});
      rdchk("unmapped", 32'h2000, 32'h0, 1'b1);
      for (int n = 0; n < 16; n++) begin
         rdchk("phase_a", 32'h1200 + 32'(8 * n), {16'h0, pa[n]}, 1'b0);
         rdchk("phase_b", 32'h1280 + 32'(8 * n), {16'h0, pb[n]}, 1'b0);
      end
      $display("table test done");
      // Oscillator stopped: output is the selected word left justified
      for (int n = 0; n < 16; n++) begin
         apb(1'b1, 32'h4, {20'h0, 4'(15 - n), 4'h0, 4'(n)});
         repeat (3) @(posedge pclk);
         chk("out_a", {pa[n], 16'h0}, phase_out_a);
         chk("out_b", {pb[15 - n], 16'h0}, phase_out_b);
         // Stopped outputs are steady, so the read-only copies can be compared
         rdchk("out reg a", 32'h8, {pa[n], 16'h0}, 1'b0);
         rdchk("out reg b", 32'hc, {pb[15 - n], 16'h0}, 1'b0);
      end
      $display("select test done");
      // Running: per-cycle step equals the frequency word of the select
      f = $random(seed);
      fb = $random(seed);
      apb(1'b1, 32'h4, 32'h0000_0505);
      apb(1'b1, 32'h1050, f);
      apb(1'b1, 32'h1150, fb);
      apb(1'b1, 32'h0, 32'h1);
      repeat (4) @(posedge pclk);
      p0 = phase_out_a;
      q0 = phase_out_b;
      repeat (5) @(posedge pclk);
      chk("step a", p0 + 32'd5 * f, phase_out_a);
      chk("step b", q0 + 32'd5 * fb, phase_out_b);
      // Rewrite while running: a wrapping jump, no oscillator restart
      p0 = phase_out_a;
      c0 = cyc;
      w = 16'h8000 | 16'($random(seed));
      apb(1'b1, 32'h1228, {16'h0, w});
      repeat (3) @(posedge pclk);
      chk("jump", p0 + 32'(cyc - c0) * f + {w - pa[5], 16'h0}, phase_out_a);
      pa[5] = w;
      // Change-block freezes the applied word until it is cleared
      apb(1'b1, 32'h0, 32'h3);
      repeat (2) @(posedge pclk);
      p0 = phase_out_a;
      c0 = cyc;
      w = 16'($random(seed));
      apb(1'b1, 32'h1228, {16'h0, w});
      repeat (3) @(posedge pclk);
      chk("frozen", p0 + 32'(cyc - c0) * f, phase_out_a);
      apb(1'b1, 32'h0, 32'h1);
      repeat (3) @(posedge pclk);
      chk("unfrozen", p0 + 32'(cyc - c0) * f + {w - pa[5], 16'h0}, phase_out_a);
      // Control, select and frequency words read back as written
      rdchk("ctrl", 32'h0, 32'h1, 1'b0);
      rdchk("select", 32'h4, 32'h0000_0505, 1'b0);
      rdchk("freq_a", 32'h1050, f, 1'b0);
      rdchk("freq_b", 32'h1150, fb, 1'b0);
      rdchk("freq misaligned", 32'h1054, 32'h0, 1'b1);
      $display("running test done");
      // Reset in mid-run must clear written phase tables, controls and outputs
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("out_a after reset", 32'h0, phase_out_a);
      chk("out_b after reset", 32'h0, phase_out_b);
      rdchk("ctrl after reset", 32'h0, 32'h0, 1'b0);
      rdchk("phase_a5 after reset", 32'h1228, 32'h0, 1'b0);
      rdchk("phase_b5 after reset", 32'h12a8, 32'h0, 1'b0);
      $display("reset test done");
      complete_run();
   end
endmodule : test_nco_hop_phase_offset
